// *** src/tw_pkg.sv ***
/*
 * Shared constants for the three-wire serial memory link: command layout,
 * access patterns, memory geometry, link timing and controller register map.
 * Assumes a 40 MHz system clock on both ends.
 */
package tw_pkg;

    // Command frame
    localparam int          CMD_BITS      = 24;
    localparam int          BYTE_BITS     = 8;
    localparam int          LOC_W         = 7;
    localparam int          MEM_DEPTH     = 128;
    localparam int          BURST_BYTES   = 128;
    localparam logic [7:0]  PAT_READ      = 8'h62;
    localparam logic [7:0]  PAT_WRITE     = 8'h9D;
    localparam int          B0_LSB        = 0;
    localparam int          B1_LSB        = 8;
    localparam int          B2_LSB        = 16;
    localparam int          RSVD_BIT      = 15;
    localparam int          BURST_BIT     = 23;

    // Link timing
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          LINK_HALF_NS  = 500;
    localparam int          RST_SETUP_NS  = 1000;
    localparam int          RST_INACT_NS  = 125;
    localparam int          CLK_MIN_NS    = 125;
    localparam int          LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RST_SETUP_CYC = (RST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RST_INACT_CYC = (RST_INACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CLK_MIN_CYC   = (CLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Controller register map (word index = haddr[4:2])
    localparam logic [2:0]  IDX_CTRL      = 3'h0;
    localparam logic [2:0]  IDX_LOC       = 3'h1;
    localparam logic [2:0]  IDX_WDATA     = 3'h2;
    localparam logic [2:0]  IDX_STATUS    = 3'h3;
    localparam logic [2:0]  IDX_RDATA     = 3'h4;
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_WRITE    = 1;
    localparam int          CTRL_BURST    = 2;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_DONE     = 1;

    function automatic logic is_cmd_pattern(input logic [7:0] b);
        is_cmd_pattern = (b == PAT_READ) || (b == PAT_WRITE);
    endfunction : is_cmd_pattern

endpackage : tw_pkg

// *** src/tw_link_if.sv ***
/*
 * Three-wire link: reset line, shift clock, shared data line.
 * The data line is resolved here; undriven it reads low (pulldown).
 */
`timescale 1ns/1ps
`default_nettype none
interface tw_link_if;
    logic rst;
    logic clk;
    logic dev_dq_o;
    logic dev_dq_oe;
    logic host_dq_o;
    logic host_dq_oe;
    logic dq;

    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 1'b0);

    modport device (input rst, input clk, input dq, output dev_dq_o, output dev_dq_oe);
    modport host   (output rst, output clk, output host_dq_o, output host_dq_oe, input dq);
endinterface : tw_link_if
`default_nettype wire

// *** src/tw_mem_dev.sv ***
/*
 * Serial memory end: 128 bytes of storage behind the three-wire link.
 * Link lines are asynchronous to hclk; they are synchronised and the shift
 * clock edges are found by sampling. Link clock must stay well below hclk/8.
 */
`timescale 1ns/1ps
`default_nettype none
module tw_mem_dev (
    // System
    input  wire logic hclk,
    input  wire logic hresetn,
    // Link
    tw_link_if.device link,
    // Status
    output logic      busy,
    output logic      aborted
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [2:0] {
        DS_IDLE  = 3'b000,
        DS_CMD   = 3'b001,
        DS_WR    = 3'b010,
        DS_RD    = 3'b011,
        DS_ABORT = 3'b100,
        DS_DONE  = 3'b101
    } tw_dev_state_type;

    typedef struct packed {
        tw_dev_state_type                 state;
        logic                             rst_s1;
        logic                             rst_s2;
        logic                             clk_s1;
        logic                             clk_s2;
        logic                             clk_d;
        logic                             dq_s1;
        logic                             dq_s2;
        logic [tw_pkg::CMD_BITS-1:0]      sr;
        logic [4:0]                       cnt;
        logic [tw_pkg::LOC_W-1:0]         loc;
        logic                             burst;
        logic [tw_pkg::LOC_W-1:0]         byte_cnt;
        logic [2:0]                       bitn;
        logic [7:0]                       dbyte;
        logic                             dq_o;
        logic                             dq_oe;
        logic [tw_pkg::MEM_DEPTH-1:0][7:0] mem;
    } tw_dev_regs_type;

    tw_dev_regs_type r;
    tw_dev_regs_type r_nxt;

    logic                        rise;
    logic                        fall;
    logic [tw_pkg::CMD_BITS-1:0] sr_nxt;
    logic [7:0]                  wbyte;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        r_nxt = r;
        r_nxt.rst_s1 = link.rst;
        r_nxt.rst_s2 = r.rst_s1;
        r_nxt.clk_s1 = link.clk;
        r_nxt.clk_s2 = r.clk_s1;
        r_nxt.clk_d  = r.clk_s2;
        r_nxt.dq_s1  = link.dq;
        r_nxt.dq_s2  = r.dq_s1;

        rise   = r.clk_s2 & ~r.clk_d;
        fall   = ~r.clk_s2 & r.clk_d;
        sr_nxt = {r.dq_s2, r.sr[tw_pkg::CMD_BITS-1:1]};
        wbyte  = {r.dq_s2, r.dbyte[7:1]};

        if (!r.rst_s2) begin
            // Reset low: end transfer, release line
            r_nxt.state = DS_IDLE;
            r_nxt.dq_oe = 1'b0;
            r_nxt.cnt   = 5'h00;
        end else begin
            case (r.state)
                DS_IDLE: begin
                    r_nxt.state = DS_CMD;
                    r_nxt.cnt   = 5'h00;
                    r_nxt.sr    = '0;
                end
                DS_CMD: begin
                    if (rise) begin
                        r_nxt.sr  = sr_nxt;
                        r_nxt.cnt = r.cnt + 5'h01;
                        if (r.cnt == 5'(tw_pkg::BYTE_BITS - 1)) begin
                            if (!tw_pkg::is_cmd_pattern(sr_nxt[tw_pkg::CMD_BITS-1 -: 8])) begin
                                r_nxt.state = DS_ABORT;
                            end
                        end else if (r.cnt == 5'(2 * tw_pkg::BYTE_BITS - 1)) begin
                            if (sr_nxt[tw_pkg::CMD_BITS-1]) begin
                                r_nxt.state = DS_ABORT;
                            end
                        end else if (r.cnt == 5'(tw_pkg::CMD_BITS - 1)) begin
                            if (sr_nxt[tw_pkg::BURST_BIT-1:tw_pkg::B2_LSB] != '0) begin
                                r_nxt.state = DS_ABORT;
                            end else begin
                                r_nxt.loc   = sr_nxt[tw_pkg::B1_LSB +: tw_pkg::LOC_W];
                                r_nxt.burst = (sr_nxt[tw_pkg::B1_LSB +: tw_pkg::LOC_W] == '0)
                                              && sr_nxt[tw_pkg::BURST_BIT];
                                r_nxt.bitn     = 3'h0;
                                r_nxt.byte_cnt = '0;
                                r_nxt.dbyte    = r.mem[sr_nxt[tw_pkg::B1_LSB +: tw_pkg::LOC_W]];
                                if (sr_nxt[tw_pkg::B0_LSB +: 8] == tw_pkg::PAT_WRITE) begin
                                    r_nxt.state = DS_WR;
                                end else begin
                                    r_nxt.state = DS_RD;
                                end
                            end
                        end
                    end
                end
                DS_RD: begin
                    if (fall) begin
                        r_nxt.dq_oe = 1'b1;
                        r_nxt.dq_o  = r.dbyte[r.bitn];
                    end
                    if (rise) begin
                        r_nxt.bitn = r.bitn + 3'h1;
                        if (r.bitn == 3'h7) begin
                            if (r.burst && r.byte_cnt != 7'(tw_pkg::BURST_BYTES - 1)) begin
                                r_nxt.byte_cnt = r.byte_cnt + 7'h01;
                                r_nxt.loc      = r.loc + 7'h01;
                                r_nxt.dbyte    = r.mem[r.loc + 7'h01];
                            end else begin
                                r_nxt.state = DS_DONE;
                            end
                        end
                    end
                end
                DS_WR: begin
                    if (rise) begin
                        r_nxt.dbyte = wbyte;
                        r_nxt.bitn  = r.bitn + 3'h1;
                        if (r.bitn == 3'h7) begin
                            r_nxt.mem[r.loc] = wbyte;
                            if (r.burst && r.byte_cnt != 7'(tw_pkg::BURST_BYTES - 1)) begin
                                r_nxt.byte_cnt = r.byte_cnt + 7'h01;
                                r_nxt.loc      = r.loc + 7'h01;
                            end else begin
                                r_nxt.state = DS_DONE;
                            end
                        end
                    end
                end
                DS_DONE: begin
                    // Hold last bit through its rising edge
                    if (fall) begin
                        r_nxt.dq_oe = 1'b0;
                    end
                end
                DS_ABORT: begin
                    r_nxt.dq_oe = 1'b0;
                end
                default: begin
                    r_nxt.state = DS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign link.dev_dq_o  = r.dq_o;
    assign link.dev_dq_oe = r.dq_oe;
    assign busy           = (r.state == DS_WR) || (r.state == DS_RD);
    assign aborted        = (r.state == DS_ABORT);

endmodule : tw_mem_dev
`default_nettype wire

// *** src/tw_host_ctrl.sv ***
/*
 * Link master: AHB-Lite register slave that runs single-byte or burst
 * transfers on the three-wire link. Makes reset and shift clock itself
 * from hclk by a divider. Zero-wait-state slave, response always OKAY.
 */
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module tw_host_ctrl #(
    parameter int HALF_CYC  = tw_pkg::LINK_HALF_CYC,
    parameter int SETUP_CYC = tw_pkg::RST_SETUP_CYC
) (
    // System
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Link
    tw_link_if.host          link
);

    generate
        if (HALF_CYC < tw_pkg::CLK_MIN_CYC || HALF_CYC > 63 || SETUP_CYC < 1 || SETUP_CYC > 63) begin : g_bad
            $error("tw_host_ctrl: timing parameter out of range");
        end
    endgenerate

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_SETUP = 3'b001,
        HS_LOW   = 3'b010,
        HS_HIGH  = 3'b011,
        HS_END   = 3'b100
    } tw_host_state_type;

    typedef struct packed {
        tw_host_state_type state;
        logic              dq_s1;
        logic              dq_s2;
        logic              wr;
        logic              burst;
        logic [6:0]        loc;
        logic [7:0]        wdata;
        logic [7:0]        rdata;
        logic [7:0]        rxb;
        logic              busy;
        logic              done;
        logic [5:0]        timer;
        logic [10:0]       bitc;
        logic              clk_o;
        logic              rst_o;
        logic              dq_o;
        logic              dq_oe;
        logic              a_valid;
        logic              a_write;
        logic [2:0]        a_idx;
        logic [31:0]       hrdata;
    } tw_host_regs_type;

    tw_host_regs_type r;
    tw_host_regs_type r_nxt;

    logic [23:0] cmd;
    logic [10:0] last_bit;
    logic        start;

    function automatic logic tx_bit(input logic [23:0] c, input logic [7:0] d, input logic [10:0] i);
        tx_bit = (i < 11'(tw_pkg::CMD_BITS)) ? c[i[4:0]] : d[i[2:0]];
    endfunction : tx_bit

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        r_nxt = r;
        r_nxt.dq_s1 = link.dq;
        r_nxt.dq_s2 = r.dq_s1;
        cmd = {r.burst, 7'h00, 1'b0, (r.burst ? 7'h00 : r.loc),
               (r.wr ? tw_pkg::PAT_WRITE : tw_pkg::PAT_READ)};
        last_bit = r.burst ? 11'(tw_pkg::CMD_BITS + 8 * tw_pkg::BURST_BYTES - 1)
                           : 11'(tw_pkg::CMD_BITS + tw_pkg::BYTE_BITS - 1);
        start = 1'b0;

        // Bus address phase
        r_nxt.a_valid = hsel && htrans[1] && hready;
        r_nxt.a_write = hwrite;
        r_nxt.a_idx   = haddr[4:2];
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[4:2])
                tw_pkg::IDX_CTRL:   r_nxt.hrdata = {29'h0, r.burst, r.wr, 1'b0};
                tw_pkg::IDX_LOC:    r_nxt.hrdata = {25'h0, r.loc};
                tw_pkg::IDX_WDATA:  r_nxt.hrdata = {24'h0, r.wdata};
                tw_pkg::IDX_STATUS: r_nxt.hrdata = {30'h0, r.done, r.busy};
                tw_pkg::IDX_RDATA:  r_nxt.hrdata = {24'h0, r.rdata};
                default:            r_nxt.hrdata = 32'h0000_0000;
            endcase
        end

        // Bus data phase
        if (r.a_valid && r.a_write && !r.busy) begin
            case (r.a_idx)
                tw_pkg::IDX_CTRL: begin
                    r_nxt.wr    = hwdata[tw_pkg::CTRL_WRITE];
                    r_nxt.burst = hwdata[tw_pkg::CTRL_BURST];
                    start       = hwdata[tw_pkg::CTRL_START];
                end
                tw_pkg::IDX_LOC:   r_nxt.loc   = hwdata[6:0];
                tw_pkg::IDX_WDATA: r_nxt.wdata = hwdata[7:0];
                default: begin
                end
            endcase
        end

        // Link sequencer
        case (r.state)
            HS_IDLE: begin
                if (start) begin
                    r_nxt.rst_o = 1'b1;
                    r_nxt.clk_o = 1'b0;
                    r_nxt.timer = 6'h00;
                    r_nxt.bitc  = 11'h000;
                    r_nxt.busy  = 1'b1;
                    r_nxt.done  = 1'b0;
                    r_nxt.state = HS_SETUP;
                end
            end
            HS_SETUP: begin
                r_nxt.timer = r.timer + 6'h01;
                if (r.timer == 6'(SETUP_CYC - 1)) begin
                    r_nxt.timer = 6'h00;
                    r_nxt.dq_oe = 1'b1;
                    r_nxt.dq_o  = tx_bit(cmd, r.wdata, 11'h000);
                    r_nxt.state = HS_LOW;
                end
            end
            HS_LOW: begin
                r_nxt.timer = r.timer + 6'h01;
                if (r.timer == 6'(HALF_CYC - 1)) begin
                    r_nxt.timer = 6'h00;
                    r_nxt.clk_o = 1'b1;
                    r_nxt.state = HS_HIGH;
                end
            end
            HS_HIGH: begin
                r_nxt.timer = r.timer + 6'h01;
                if (r.timer == 6'(HALF_CYC - 1)) begin
                    r_nxt.timer = 6'h00;
                    // Read bit taken late in the high half, well past the device's fall latency
                    if (!r.wr && r.bitc >= 11'(tw_pkg::CMD_BITS)) begin
                        r_nxt.rxb = {r.dq_s2, r.rxb[7:1]};
                        if (r.bitc[2:0] == 3'h7) begin
                            r_nxt.rdata = {r.dq_s2, r.rxb[7:1]};
                        end
                    end
                    if (r.bitc == last_bit) begin
                        r_nxt.rst_o = 1'b0;
                        r_nxt.dq_oe = 1'b0;
                        r_nxt.state = HS_END;
                    end else begin
                        r_nxt.bitc  = r.bitc + 11'h001;
                        r_nxt.clk_o = 1'b0;
                        r_nxt.dq_oe = r.wr || (r.bitc + 11'h001 < 11'(tw_pkg::CMD_BITS));
                        r_nxt.dq_o  = tx_bit(cmd, r.wdata, r.bitc + 11'h001);
                        r_nxt.state = HS_LOW;
                    end
                end
            end
            HS_END: begin
                r_nxt.timer = r.timer + 6'h01;
                if (r.timer == 6'(tw_pkg::RST_INACT_CYC - 1)) begin
                    r_nxt.clk_o = 1'b0;
                    r_nxt.busy  = 1'b0;
                    r_nxt.done  = 1'b1;
                    r_nxt.state = HS_IDLE;
                end
            end
            default: begin
                r_nxt.state = HS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = r.hrdata;
    assign link.rst        = r.rst_o;
    assign link.clk        = r.clk_o;
    assign link.host_dq_o  = r.dq_o;
    assign link.host_dq_oe = r.dq_oe;

endmodule : tw_host_ctrl
`default_nettype wire

// *** verification/tw_link_assertions.sv ***
/* Checker on the three-wire link between host controller and memory end.
   Assumes link lines come from hclk registers; hresetn low resets. */
`timescale 1ns/1ps
`default_nettype none
module tw_link_assertions #(
    parameter int HALF_CYC = 5
) (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic rst,
    input wire logic clk,
    input wire logic dev_dq_o,
    input wire logic dev_dq_oe,
    input wire logic host_dq_o,
    input wire logic host_dq_oe
);
    logic        clk_r;
    logic [10:0] rise_r;
    logic [7:0]  fall_r, hold_r;

    // Rises per frame, age of last fall, length of current half
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_r <= 1'b0;
            rise_r <= 11'h000;
            fall_r <= 8'hFF;
            hold_r <= 8'h00;
        end else begin
            clk_r <= clk;
            rise_r <= rst ? rise_r + {10'h000, clk & ~clk_r} : 11'h000;
            fall_r <= (clk_r & ~clk) ? 8'h00 : fall_r + {7'h00, fall_r != 8'hFF};
            hold_r <= (clk != clk_r) ? 8'h00 : hold_r + {7'h00, hold_r != 8'hFF};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_setup_low; !clk [*4]; endsequence
    sequence s_dq_hold; $stable(host_dq_o) [*3]; endsequence

    AST_SETUP: assert property ($rose(rst) |-> s_setup_low)
        else $error("clock not low after frame start");
    AST_HALF: assert property ($changed(clk) && rst && $past(rst) |-> hold_r >= 8'(HALF_CYC - 1))
        else $error("clock half too short");
    AST_DQ_ON_LOW: assert property (host_dq_oe && $changed(host_dq_o) |-> !clk)
        else $error("host data moved with clock high");
    AST_DQ_HOLD: assert property ($rose(clk) && host_dq_oe |-> s_dq_hold)
        else $error("host data not held over rise");
    AST_OE_AT_24: assert property ($rose(dev_dq_oe) |-> rise_r == 11'h018 && !clk && !host_dq_oe)
        else $error("device drive began at wrong clock");
    AST_OUT_ON_FALL: assert property (dev_dq_oe && $past(dev_dq_oe) && $changed(dev_dq_o)
        |-> !clk && fall_r <= 8'h08)
        else $error("device data moved away from a fall");
    AST_RELEASE: assert property ($fell(rst) |-> ##[1:6] !dev_dq_oe)
        else $error("device kept driving after frame end");
    AST_QUIET: assert property (!rst [*8] |-> !dev_dq_oe && !clk)
        else $error("activity while link reset low");
    AST_RISE_LIMIT: assert property ($rose(clk) |-> rise_r < 11'h418)
        else $error("too many clocks in frame");
    AST_READ_LEN: assert property ($fell(rst) && $past(dev_dq_oe) |-> (rise_r == 11'h020 || rise_r == 11'h418))
        else $error("read frame length wrong");
    AST_DROP_HIGH: assert property ($fell(rst) |-> clk)
        else $error("frame ended with clock low");
endmodule : tw_link_assertions
`default_nettype wire

// *** verification/three_wire_serial_memory_tag_tb_top.sv ***
/* Bench: AHB-Lite master on the host controller, memory end across the link;
   a second memory end driven by hand gets broken commands and well-formed single and burst reads.
   Assumes package, link interface and both ends compiled first. */
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_memory_tag_tb_top;
    logic        hclk, hresetn, hsel, hwrite, want, dph, hreadyout, hresp;
    logic        busy, aborted, busy_b, aborted_b;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  byte_exp [3];
    logic [6:0]  locs [3];
    logic [24:0] cmds [5];
    logic [31:0] exp_q [$];
    int          failures, checked;

    tw_link_if link ();
    tw_link_if link_b ();
    tw_host_ctrl #(.HALF_CYC(5), .SETUP_CYC(4)) i_tw_host_ctrl (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
    tw_mem_dev i_tw_mem_dev (.hclk(hclk), .hresetn(hresetn), .link(link), .busy(busy), .aborted(aborted));
    tw_mem_dev i_tw_mem_dev_b (.hclk(hclk), .hresetn(hresetn), .link(link_b), .busy(busy_b),
        .aborted(aborted_b));
    tw_link_assertions #(.HALF_CYC(5)) i_tw_link_assertions (.hclk(hclk), .hresetn(hresetn),
        .rst(link.rst), .clk(link.clk), .dev_dq_o(link.dev_dq_o), .dev_dq_oe(link.dev_dq_oe),
        .host_dq_o(link.host_dq_o), .host_dq_oe(link.host_dq_oe));

    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic results;
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic note);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        want <= note;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic check_rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h0, 1'b1);
    endtask : check_rd

    // Start a transfer, see it busy, then poll until done
    task automatic run(input logic [31:0] ctrl);
        ahb(1'b1, 32'h0, ctrl, 1'b0);
        check_rd(32'hC, 32'h1);
        do ahb(1'b0, 32'hC, 32'h0, 1'b0); while (rd[1] !== 1'b1);
        cmp({30'h0, busy, aborted}, 32'h0);
    endtask : run

    // Hand-made frame on the second link
    task automatic frame_b(input logic [23:0] c, input logic e);
        link_b.rst <= 1'b1;
        repeat (40) @(posedge hclk);
        for (int i = 0; i < 24; i++) begin
            link_b.host_dq_o <= c[i];
            repeat (4) @(posedge hclk);
            link_b.clk <= 1'b1;
            repeat (4) @(posedge hclk);
            link_b.clk <= 1'b0;
        end
        repeat (8) @(posedge hclk);
        cmp({29'h0, busy_b, link_b.dev_dq_oe, aborted_b}, {29'h0, ~e, ~e, e});
        link_b.clk <= 1'b1;
        repeat (4) @(posedge hclk);
        link_b.rst <= 1'b0;
        repeat (4) @(posedge hclk);
        link_b.clk <= 1'b0;
        repeat (8) @(posedge hclk);
        cmp({29'h0, busy_b, link_b.dev_dq_oe, aborted_b}, 32'h0);
    endtask : frame_b

    // Result watcher
    always @(posedge hclk) begin
        if (dph) begin
            cmp(hrdata, exp_q.pop_front());
        end
        dph = hsel && htrans[1] && !hwrite && want && hreadyout;
    end

    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, want, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {link_b.rst, link_b.clk, link_b.host_dq_o, link_b.host_dq_oe} = 4'h1;
        failures = 0;
        checked = 0;
        locs = '{7'h01, 7'h55, 7'h7F};
        cmds = '{25'h0000562, 25'h1000563, 25'h1008562, 25'h140009D, 25'h0800062};
        void'($urandom(19));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b1, 32'h1C, 32'hFFFFFFFF, 1'b0);
        check_rd(32'h1C, 32'h0);
        for (int k = 0; k < 3; k++) begin
            byte_exp[k] = 8'($urandom());
            ahb(1'b1, 32'h4, {25'h0, locs[k]}, 1'b0);
            ahb(1'b1, 32'h8, {24'h0, byte_exp[k]}, 1'b0);
            run(32'h3);
        end
        for (int k = 0; k < 3; k++) begin
            ahb(1'b1, 32'h4, {25'h0, locs[k]}, 1'b0);
            run(32'h1);
            check_rd(32'h10, {24'h0, byte_exp[k]});
        end
        byte_exp[0] = 8'($urandom());
        ahb(1'b1, 32'h8, {24'h0, byte_exp[0]}, 1'b0);
        run(32'h7);
        ahb(1'b1, 32'h4, 32'h7F, 1'b0);
        ahb(1'b1, 32'h8, {24'h0, ~byte_exp[0]}, 1'b0);
        run(32'h3);
        run(32'h5);
        check_rd(32'h10, {24'h0, ~byte_exp[0]});
        ahb(1'b1, 32'h4, 32'h55, 1'b0);
        run(32'h1);
        check_rd(32'h10, {24'h0, byte_exp[0]});
        for (int k = 0; k < 5; k++) begin
            frame_b(cmds[k][23:0], cmds[k][24]);
        end
        results();
    end
endmodule : three_wire_serial_memory_tag_tb_top
`default_nettype wire
